// *** eq_setb_pkg.sv ***
// Register map and field layout of the alternate set, second channel
package eq_setb_pkg;

  // Register count and APB geometry
  localparam int          NUM_REGS   = 12;
  localparam int          DATA_W     = 32;
  localparam int          REG_W      = 8;
  localparam int          NUM_TAPS   = 9;
  localparam int          GAIN_W     = 6;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_TAP0   = 10'h060;
  localparam logic [9:0]  IDX_TAP1   = 10'h061;
  localparam logic [9:0]  IDX_TAP2   = 10'h062;
  localparam logic [9:0]  IDX_TAP3   = 10'h063;
  localparam logic [9:0]  IDX_TAP4   = 10'h064;
  localparam logic [9:0]  IDX_TAP5   = 10'h065;
  localparam logic [9:0]  IDX_TAP6   = 10'h066;
  localparam logic [9:0]  IDX_TAP7   = 10'h067;
  localparam logic [9:0]  IDX_TAP8   = 10'h068;
  localparam logic [9:0]  IDX_PREDRV = 10'h069;
  localparam logic [9:0]  IDX_OFS    = 10'h06A;
  localparam logic [9:0]  IDX_AGC    = 10'h06B;

  // Slot numbers inside the local array
  localparam logic [3:0]  SLOT_PREDRV = 4'h9;
  localparam logic [3:0]  SLOT_OFS    = 4'hA;
  localparam logic [3:0]  SLOT_AGC    = 4'hB;

  // Tap register fields
  localparam int          TAP_EN_BIT   = 7;
  localparam int          TAP_POS_BIT  = 6;
  localparam int          TAP_GAIN_MSB = 5;

  // Predriver, offset and amplitude fields
  localparam int          PRED_GAIN_MSB = 5;
  localparam int          OFS_AUTO_BIT  = 6;
  localparam int          OFS_SIGN_BIT  = 5;
  localparam int          OFS_MAG_MSB   = 4;
  localparam int          AGC_AMP_MSB   = 2;

  // Reset values; taps 5 to 8 share one
  localparam logic [7:0]  RST_TAP0   = 8'hC0;
  localparam logic [7:0]  RST_TAP1   = 8'h84;
  localparam logic [7:0]  RST_TAP2   = 8'hFF;
  localparam logic [7:0]  RST_TAP3   = 8'hA8;
  localparam logic [7:0]  RST_TAP4   = 8'h84;
  localparam logic [7:0]  RST_TAP5_8 = 8'hC0;
  localparam logic [7:0]  RST_PREDRV = 8'h3F;
  localparam logic [7:0]  RST_OFS    = 8'h40;
  localparam logic [7:0]  RST_AGC    = 8'h04;

  // Reset table indexed by slot
  localparam logic [7:0]  REG_RST [NUM_REGS] = '{
    RST_TAP0, RST_TAP1, RST_TAP2, RST_TAP3, RST_TAP4, RST_TAP5_8,
    RST_TAP5_8, RST_TAP5_8, RST_TAP5_8, RST_PREDRV, RST_OFS, RST_AGC
  };

endpackage : eq_setb_pkg

// *** eq_setb_regs.sv ***
// Operation
// RULE_01 - Tap bit 7 enables the tap
// RULE_02 - Tap bit 6 one means positive
// RULE_03 - Tap bits 5:0 hold gain magnitude
// RULE_04 - Tap 2 resets enabled, positive, full
// RULE_05 - Tap 3 resets enabled, negative, 0x28
// RULE_06 - Tap 4 resets enabled, negative, four
// RULE_07 - Taps 5-8 reset enabled, positive, zero
// RULE_08 - Predriver gain 5:0, resets 0x3F
// RULE_09 - Offset bit 6 auto enable, resets one
// RULE_10 - Manual offset sign and magnitude reset zero
// RULE_11 - Amplitude bits 2:0 reset to 100
// RULE_12 - Taps 0 and 1 reset values
// RULE_13 - Software preserves factory bits by read-modify-write
`timescale 1ns/1ps
module eq_setb_regs
  import eq_setb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [DATA_W-1:0]            pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic                              pready,
  output logic [DATA_W-1:0]                 prdata,
  output logic                              pslverr,
  output logic [NUM_TAPS-1:0]               tap_en,
  output logic [NUM_TAPS-1:0]               tap_pos,
  output logic [NUM_TAPS*GAIN_W-1:0]        tap_gain,
  output logic [PRED_GAIN_MSB:0]            predrv_gain,
  output logic                              ofs_auto_en,
  output logic                              ofs_man_sign,
  output logic [OFS_MAG_MSB:0]              ofs_man_mag,
  output logic [AGC_AMP_MSB:0]              agc_amp
);

  // Register storage, one byte per slot
  logic [REG_W-1:0]    cfg_r [NUM_REGS];
  // Access handshake flops
  logic                pready_r;
  logic [DATA_W-1:0]   prdata_r;
  logic                pslverr_r;
  // Word index and decode
  logic [ADDR_W-3:0]   word_idx;
  logic                hit;
  logic [3:0]          slot;
  // Setup and completion strobes
  logic                setup_go;
  logic                done_go;
  logic                wr_go;

  // Address decode of the mapped window
  always_comb begin
    word_idx = paddr[ADDR_W-1:2];
    // Aligned words inside the index range only
    hit      = (paddr[1:0] == 2'b00) && (word_idx >= (ADDR_W-2)'(IDX_TAP0)) &&
               (word_idx <= (ADDR_W-2)'(IDX_AGC));
    // Slot is only meaningful while hit is high
    slot     = 4'(word_idx - (ADDR_W-2)'(IDX_TAP0));
  end

  // Phase strobes of the bus
  assign setup_go = psel && !penable;
  assign done_go  = psel && penable && pready_r;
  // Low byte lane must be strobed to write
  assign wr_go    = done_go && pwrite && hit && pstrb[0];

  // Ready for exactly the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_go;
    end
  end

  // Error for unmapped or misaligned address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup_go) begin
      pslverr_r <= !hit;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_go && !pwrite && hit) begin
      // Narrow register in the low byte, upper bits zero
      prdata_r <= {{(DATA_W-REG_W){1'b0}}, cfg_r[slot]};
    end else begin
      prdata_r <= '0;
    end
  end

  // One process per register slot
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    // RULE_04 reset value load
    // RULE_05 reset value load
    // RULE_06 reset value load
    // RULE_07 reset value load
    // RULE_12 reset value load
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_r[i] <= REG_RST[i];
      end else if (wr_go && (slot == 4'(i))) begin
        // Whole byte stored, factory bits included
        cfg_r[i] <= pwdata[REG_W-1:0];
      end
    end
  end

  // Tap fields fan out straight from storage
  for (genvar t = 0; t < NUM_TAPS; t++) begin : g_tap
    // RULE_01 enable bit out
    assign tap_en[t]  = cfg_r[t][TAP_EN_BIT];
    // RULE_02 polarity bit out
    assign tap_pos[t] = cfg_r[t][TAP_POS_BIT];
    // RULE_03 gain magnitude out
    assign tap_gain[t*GAIN_W +: GAIN_W] = cfg_r[t][TAP_GAIN_MSB:0];
  end

  // RULE_08 predriver gain field
  assign predrv_gain  = cfg_r[SLOT_PREDRV][PRED_GAIN_MSB:0];
  // RULE_09 automatic offset enable
  assign ofs_auto_en  = cfg_r[SLOT_OFS][OFS_AUTO_BIT];
  // RULE_10 manual offset fields
  assign ofs_man_sign = cfg_r[SLOT_OFS][OFS_SIGN_BIT];
  assign ofs_man_mag  = cfg_r[SLOT_OFS][OFS_MAG_MSB:0];
  // RULE_11 amplitude setting
  assign agc_amp      = cfg_r[SLOT_AGC][AGC_AMP_MSB:0];

  // Bus outputs from their flops
  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // Checks share one clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // First cycle out of reset
  logic first_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // RULE_01 enable follows write
  chk_tap_en_write: assert property ( // RULE_01
    wr_go && (slot < 4'(NUM_TAPS)) |=> tap_en[$past(slot)] == $past(pwdata[TAP_EN_BIT])
  ) else $error("tap enable did not follow write");

  // RULE_02 polarity follows write
  chk_tap_pos_write: assert property ( // RULE_02
    wr_go && (slot < 4'(NUM_TAPS)) |=> tap_pos[$past(slot)] == $past(pwdata[TAP_POS_BIT])
  ) else $error("tap polarity did not follow write");

  // RULE_03 gain readback matches write
  chk_tap_gain_rb: assert property ( // RULE_03
    wr_go && (slot == 4'h2) ##1 setup_go && !pwrite && hit && (slot == 4'h2)
      |=> prdata[TAP_GAIN_MSB:0] == $past(pwdata[TAP_GAIN_MSB:0], 2)
  ) else $error("tap gain readback mismatch");

  // RULE_04 tap 2 after reset
  chk_tap2_reset: assert property ( // RULE_04
    first_r |-> tap_en[2] && tap_pos[2] && tap_gain[2*GAIN_W +: GAIN_W] == 6'h3F
  ) else $error("tap 2 reset value wrong");

  // RULE_05 tap 3 after reset
  chk_tap3_reset: assert property ( // RULE_05
    first_r |-> tap_en[3] && !tap_pos[3] && tap_gain[3*GAIN_W +: GAIN_W] == 6'h28
  ) else $error("tap 3 reset value wrong");

  // RULE_06 tap 4 after reset
  chk_tap4_reset: assert property ( // RULE_06
    first_r |-> tap_en[4] && !tap_pos[4] && tap_gain[4*GAIN_W +: GAIN_W] == 6'h04
  ) else $error("tap 4 reset value wrong");

  // RULE_07 taps 5 to 8 after reset
  chk_tap5_8_reset: assert property ( // RULE_07
    first_r |-> tap_en[8:5] == 4'hF && tap_pos[8:5] == 4'hF &&
      tap_gain[NUM_TAPS*GAIN_W-1:5*GAIN_W] == 24'h000000
  ) else $error("taps 5 to 8 reset value wrong");

  // RULE_08 predriver whole byte after reset
  chk_predrv_reset: assert property ( // RULE_08
    first_r |-> cfg_r[SLOT_PREDRV] == 8'h3F && predrv_gain == 6'h3F
  ) else $error("predriver reset value wrong");

  // RULE_09 auto offset after reset and write
  chk_ofs_auto: assert property ( // RULE_09
    (first_r |-> ofs_auto_en && !cfg_r[SLOT_OFS][7]) and
    (wr_go && slot == SLOT_OFS |=> ofs_auto_en == $past(pwdata[OFS_AUTO_BIT]))
  ) else $error("auto offset enable wrong");

  // RULE_10 manual offset after reset
  chk_ofs_manual: assert property ( // RULE_10
    first_r |-> !ofs_man_sign && ofs_man_mag == 5'h00
  ) else $error("manual offset reset value wrong");

  // RULE_11 amplitude byte after reset
  chk_agc_reset: assert property ( // RULE_11
    first_r |-> cfg_r[SLOT_AGC] == 8'h04 && agc_amp == 3'h4
  ) else $error("amplitude reset value wrong");

  // RULE_12 taps 0 and 1 after reset
  chk_tap01_reset: assert property ( // RULE_12
    first_r |-> tap_en[1:0] == 2'h3 && tap_pos[1:0] == 2'h1 &&
      tap_gain[2*GAIN_W-1:0] == 12'h100
  ) else $error("taps 0 and 1 reset value wrong");

  // Bus answers in the first access cycle
  chk_apb_ready: assert property (
    setup_go |=> pready ##1 !pready
  ) else $error("ready not one cycle after setup");

  // Unmapped address flagged
  chk_apb_err: assert property (
    setup_go && !hit |=> pslverr && pready
  ) else $error("unmapped access not flagged");

  // Notes on use
  // Factory bits are stored as written; software writes them back unchanged
  // Read data is taken in the setup cycle; no write lands before the access edge
  // Every access ends with zero wait states, refused ones included
  // Writes with lane 0 unstrobed are dropped without an error
  // Chained setups right after an access are accepted

  // Whole bank as one vector, for hold checks
  logic [NUM_REGS*REG_W-1:0] cfg_flat;
  for (genvar j = 0; j < NUM_REGS; j++) begin : g_flat
    // One byte lane per slot
    assign cfg_flat[j*REG_W +: REG_W] = cfg_r[j];
  end

  // Only the first access cycle answers
  chk_done_once: assert property (
    done_go |=> !pready
  ) else $error("ready held past one access cycle");

  // Ready only follows a setup cycle
  chk_ready_cause: assert property (
    !setup_go |=> !pready
  ) else $error("ready without a setup cycle");

  // Mapped access never flagged
  chk_apb_ok: assert property (
    setup_go && hit |=> !pslverr
  ) else $error("mapped access flagged");

  // Error only stands together with ready
  chk_err_ready: assert property (
    pslverr |-> pready
  ) else $error("error without ready");

  // Decode never selects a slot past the bank
  chk_hit_range: assert property (
    hit |-> slot < 4'(NUM_REGS)
  ) else $error("decoded slot out of range");

  // Read data stands only in a read access cycle
  chk_rd_idle_zero: assert property (
    !(setup_go && !pwrite && hit) |=> prdata == '0
  ) else $error("read data outside a read access");

  // RULE_01 readback agrees with fields
  chk_rd_fields: assert property ( // RULE_01
    setup_go && !pwrite && hit && (slot < 4'(NUM_TAPS)) |=>
      prdata == {24'h000000, tap_en[$past(slot)], tap_pos[$past(slot)],
                 tap_gain[$past(slot)*GAIN_W +: GAIN_W]}
  ) else $error("tap readback disagrees with fields");

  // RULE_03 gain follows write
  chk_tap_gain_write: assert property ( // RULE_03
    wr_go && (slot < 4'(NUM_TAPS)) |=>
      tap_gain[$past(slot)*GAIN_W +: GAIN_W] == $past(pwdata[TAP_GAIN_MSB:0])
  ) else $error("tap gain did not follow write");

  // RULE_08 predriver gain follows write
  chk_predrv_write: assert property ( // RULE_08
    wr_go && (slot == SLOT_PREDRV) |=> predrv_gain == $past(pwdata[PRED_GAIN_MSB:0])
  ) else $error("predriver gain did not follow write");

  // RULE_10 manual offset follows write
  chk_ofs_man_write: assert property ( // RULE_10
    wr_go && (slot == SLOT_OFS) |=>
      {ofs_man_sign, ofs_man_mag} == $past(pwdata[OFS_SIGN_BIT:0])
  ) else $error("manual offset did not follow write");

  // RULE_11 amplitude follows write
  chk_agc_write: assert property ( // RULE_11
    wr_go && (slot == SLOT_AGC) |=> agc_amp == $past(pwdata[AGC_AMP_MSB:0])
  ) else $error("amplitude did not follow write");

  // Factory bits stored as written
  chk_factory_kept: assert property (
    (wr_go && (slot == SLOT_PREDRV) |=> cfg_r[SLOT_PREDRV][7:6] == $past(pwdata[7:6])) and
    (wr_go && (slot == SLOT_AGC) |=> cfg_r[SLOT_AGC][7:3] == $past(pwdata[7:3]))
  ) else $error("factory bits not stored as written");

  // Bank holds without an accepted write
  chk_bank_hold: assert property (
    !wr_go |=> cfg_flat == $past(cfg_flat)
  ) else $error("register changed without a write");

  // Unstrobed low lane drops the write
  chk_strb_drop: assert property (
    done_go && pwrite && !pstrb[0] |=> cfg_flat == $past(cfg_flat)
  ) else $error("write landed without lane 0 strobe");

  // Each slot changes only on its own write
  for (genvar s = 0; s < NUM_REGS; s++) begin : g_slot_chk
    chk_slot_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_go && (slot == 4'(s))) |=> cfg_r[s] == $past(cfg_r[s])
    ) else $error("slot changed without its own write");
  end

  // Main scenarios
  cov_tap_write: cover property (wr_go && slot < 4'(NUM_TAPS));
  cov_ofs_write: cover property (wr_go && slot == SLOT_OFS);
  cov_read_hit:  cover property (setup_go && !pwrite && hit ##1 done_go);
  cov_unmapped:  cover property (setup_go && !hit ##1 pslverr);
  cov_chained:   cover property (done_go ##1 setup_go ##1 done_go);

endmodule : eq_setb_regs

// *** eq_setb_regs_test.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module eq_setb_regs_test;
  import eq_setb_pkg::*;
  // Bus and clock drive
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]               paddr = 12'h000;
  logic [DATA_W-1:0]         pwdata = 32'h0;
  logic [3:0]                pstrb = 4'h0;
  // Design outputs
  logic                      pready, pslverr;
  logic [DATA_W-1:0]         prdata;
  logic [NUM_TAPS-1:0]       tap_en, tap_pos;
  logic [NUM_TAPS*GAIN_W-1:0] tap_gain;
  logic [5:0]                predrv_gain;
  logic                      ofs_auto_en, ofs_man_sign;
  logic [4:0]                ofs_man_mag;
  logic [2:0]                agc_amp;
  // Bench state
  int                        error_cnt = 0, checks_done = 0;
  logic [31:0]               seed = 32'hAE04;
  logic [7:0]                model [12];
  logic [31:0]               rd;
  logic                      err;
  // Chaining: keep holds psel for the next call, linked skips its idle edge
  logic                      keep = 1'b0, linked = 1'b0;
  // Expected reset image, slot order tap0..tap8, predriver, offset, amplitude
  localparam logic [7:0] RST_IMG [12] = '{8'hC0, 8'h84, 8'hFF, 8'hA8, 8'h84, 8'hC0,
    8'hC0, 8'hC0, 8'hC0, 8'h3F, 8'h40, 8'h04};
  // Factory bits per slot
  localparam logic [7:0] FMASK [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hC0, 8'h80, 8'hF8};

  eq_setb_regs #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .tap_en(tap_en),
    .tap_pos(tap_pos), .tap_gain(tap_gain), .predrv_gain(predrv_gain),
    .ofs_auto_en(ofs_auto_en), .ofs_man_sign(ofs_man_sign), .ofs_man_mag(ofs_man_mag),
    .agc_amp(agc_amp));

  // Clock, 10 ns period
  always #5 pclk = ~pclk;

  // Xorshift source
  function automatic logic [31:0] xrand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xrand

  // Expected byte after a write: lane 0 strobe decides
  function automatic logic [7:0] next_byte(input logic [7:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
    return st[0] ? wd[7:0] : old;
  endfunction : next_byte

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    if (!linked)
      @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // A chained call raises the next setup in this same step
    if (!keep) begin
      psel <= 1'b0; penable <= 1'b0;
    end
    linked = keep;
    keep = 1'b0;
  endtask : apb

  // Reads every slot and checks data and field outputs against the model
  task automatic check_all(input string name);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 12'(10'h060 + i) << 2, 32'h0, 4'h0);
      `CHK({rd, err}, {24'h0, model[i], 1'b0})
    end
    for (int t = 0; t < NUM_TAPS; t++) begin
      `CHK(tap_en[t], model[t][7])
      `CHK(tap_pos[t], model[t][6])
      `CHK(tap_gain[6*t +: 6], model[t][5:0])
    end
    `CHK(predrv_gain, model[9][5:0])
    `CHK(ofs_auto_en, model[10][6])
    `CHK({ofs_man_sign, ofs_man_mag}, model[10][5:0])
    `CHK(agc_amp, model[11][2:0])
    $display("test %s done", name);
  endtask : check_all

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Hang guard
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    int idx;
    logic [31:0] d;
    logic [3:0] st;
    model = RST_IMG;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check_all("reset");
    // Random writes, corner values first
    for (int k = 0; k < 60; k++) begin
      seed = xrand(seed);
      idx = (k < 12) ? k : int'(seed[19:16]) % 12;
      d = (k < 12) ? 32'hFFFF_FF3F : seed;
      st = (k < 12) ? 4'hF : seed[27:24];
      d[7:0] = (d[7:0] & ~FMASK[idx]) | (RST_IMG[idx] & FMASK[idx]);
      // Write, then read back with no idle cycle between
      keep = 1'b1;
      apb(1'b1, 12'(10'h060 + idx) << 2, d, st);
      `CHK(err, 1'b0)
      model[idx] = next_byte(model[idx], d, st);
      apb(1'b0, 12'(10'h060 + idx) << 2, 32'h0, 4'h0);
      `CHK({rd, err}, {24'h0, model[idx], 1'b0})
    end
    check_all("random");
    // Unmapped and misaligned addresses are refused
    apb(1'b1, 12'h1B0, 32'h0, 4'hF);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h181, 32'h0, 4'hF);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h1B0, 32'h0, 4'h0);
    `CHK({rd, err}, {32'h0, 1'b1})
    check_all("refused");
    // Reset in mid-run restores every slot
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    model = RST_IMG;
    check_all("second_reset");
    complete_run();
  end
endmodule : eq_setb_regs_test
